// ### verilog/tmr_defs.svh
/*
   Constants for the timer, watchdog, shared prescaler and reset
   controller: register offsets, field positions, reset values,
   instruction codes and timing counts.
   Assumes a 40 MHz core clock and inclusion by bare name.
*/
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define ADDR_MAIN_TIMER 7'h01
`define ADDR_STATUS     7'h03

`define SEL_RATIO_MSB   2
`define SEL_ASSIGN_BIT  3
`define SEL_EDGE_BIT    4
`define SEL_SOURCE_BIT  5
`define SEL_RESET       6'h3f

`define ST_PAGE_BIT     5
`define ST_TIMEOUT_BIT  4
`define ST_PWRDN_BIT    3
`define ST_ALU_MSB      2
`define ST_COLD_RESET   8'h18

`define OP_CLRWDT       14'h2001
`define OP_SELECT       14'h2002
`define OP_SLEEP        14'h2003

`define PHASE_T2        2'h1
`define PHASE_T4        2'h3

`define CLK_KHZ         40000
`define RST_HOLD_MS     20
`define RST_HOLD_CYC    (`RST_HOLD_MS * `CLK_KHZ)
`define WDT_PERIOD_MS   20
`define WDT_STEPS       256
`define WDT_TICK_CYC    ((`WDT_PERIOD_MS * `CLK_KHZ) / `WDT_STEPS)

`endif

// ### verilog/tmr_pkg.sv
/*
   Types shared by the timer/watchdog/reset block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package tmr_pkg;

   typedef enum logic [1:0] {COLD_HOLD, WARM_HOLD, RUN} rst_state_e;

   typedef logic [7:0] byte_t;

endpackage

// ### verilog/scaler_if.sv
/*
   Carrier between the top module and the shared prescaler.
   Assumes the owner drives the event, clear and ratio every cycle.
*/
interface scaler_if;
   logic       ev;
   logic       clr;
   logic [2:0] ratio;
   logic       shift;
   logic       tick;

   modport owner  (output ev, clr, ratio, shift, input tick);
   modport scaler (input ev, clr, ratio, shift, output tick);
endinterface

// ### verilog/count_edge_sync.sv
/*
   Synchroniser and edge picker for the external count pin.
   Assumes sample_en pulses at the T2 and T4 phases of the core clock.
*/
module count_edge_sync
(
   input  wire logic clk,         // core clock
   input  wire logic sys_rst,     // synchronous reset
   input  wire logic pin,         // asynchronous count pin
   input  wire logic sample_en,   // T2/T4 phase strobe
   input  wire logic falling_sel, // 1: count high-to-low
   output logic      edge_pulse   // one count event
);
   logic sync1_q;
   logic sync2_q;
   logic samp_q;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end
      else
      begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
      end
   end

   // pulses shorter than two sample points can slip between them
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         samp_q <= 1'b0;
      else if (sample_en)
         samp_q <= sync2_q;
   end

   assign edge_pulse = sample_en && (falling_sel ? (samp_q && !sync2_q)
                                                 : (!samp_q && sync2_q));

   a_edge_direction: assert property (@(posedge clk) disable iff (sys_rst)
      edge_pulse |=> samp_q == !$past(falling_sel))
      else $error("count edge taken in the wrong direction");

   a_edge_on_phase: assert property (@(posedge clk) disable iff (sys_rst)
      edge_pulse |-> sample_en)
      else $error("count edge taken outside a sample phase");
endmodule

// ### verilog/ratio_scaler.sv
/*
   Shared 8-bit prescaler; ticks once every 2^(ratio+shift) events.
   Assumes the owner selects shift=1 for the timer, 0 for the watchdog.
*/
module ratio_scaler
(
   input  wire logic clk,     // core clock
   input  wire logic sys_rst, // synchronous reset
   scaler_if.scaler  sif      // event, clear, ratio and tick
);
   logic [7:0] cnt_q;
   logic [7:0] mask;
   logic [3:0] span;

   assign span = {1'b0, sif.ratio} + {3'h0, sif.shift};

   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_mask
         assign mask[i] = (4'(i) < span);
      end
   endgenerate

   assign sif.tick = sif.ev && ((cnt_q & mask) == mask);

   // clear wins over a coincident event
   always_ff @(posedge clk)
   begin
      if (sys_rst || sif.clr)
         cnt_q <= 8'h00;
      else if (sif.ev)
         cnt_q <= cnt_q + 8'h01;
   end

   a_scaler_clear: assert property (@(posedge clk) disable iff (sys_rst)
      sif.clr |=> cnt_q == 8'h00)
      else $error("prescaler not cleared");

   a_scaler_wrap: assert property (@(posedge clk) disable iff (sys_rst)
      sif.tick && !sif.clr |=> (cnt_q & $past(mask)) == 8'h00)
      else $error("prescaler tick off its ratio");
endmodule

// ### verilog/timer_watchdog_prescaler_reset.sv
/*
   Timer/counter, watchdog, shared prescaler and reset controller of a
   small microcontroller core.
   Assumes the core presents executed instruction words and register
   accesses on clk, and holds its own state in reset on chip_rst_q.
*/
// Behaviour
// - main timer is an 8-bit up counter on instruction clock or count pin
// - internal source, no prescaler: timer adds one each instruction cycle
// - source select set: count pin edges, edge select picks direction
// - edge select zero counts rising edges, one counts falling edges
// - count pin sampled at T2 and T4; short pulses may be lost
// - watchdog is an 8-bit counter on its own on-chip oscillator
// - watchdog keeps counting while asleep
// - watchdog time-out restarts chip and clears time-out flag
// - watchdog post-scale ratio 111 gives division 1:128
// - the single prescaler serves the timer or the watchdog, never both
// - prescaler on watchdog: clear-watchdog or sleep clears both
// - prescaler on timer: any timer write clears the prescaler
// - configuration load copies accumulator; default value is 3F
// - reset on power-on, pin low, or watchdog time-out if fuse set
// - power-on is cold; pin and watchdog resets are warm
// - cold reset holds the chip about 20 ms
// - every reset sets control to ones; warm keeps timer
// - cold status 0001 1; warm clears page, sets cause flags except on pin reset while awake, keeps ALU
// - time-out and power-down flags encode the reset cause
// - word 10 0000 0000 0011 is sleep and updates both flags
`include "tmr_defs.svh"
module timer_watchdog_prescaler_reset
   import tmr_pkg::*;
#(
   parameter int unsigned RST_HOLD_CYC = `RST_HOLD_CYC,
   parameter int unsigned WDT_TICK_CYC = `WDT_TICK_CYC
)
(
   input  wire logic        clk,                  // 40 MHz core clock
   input  wire logic        sys_rst,              // power-on reset
   input  wire logic        reset_pin_n,          // external reset pin
   input  wire logic        timer_count_pin,      // external count pin
   input  wire logic        watchdog_enable_fuse, // config fuse
   input  wire logic        instr_exec,           // instruction executes
   input  wire logic [13:0] instr_word,           // its opcode
   input  wire logic [7:0]  acc_in,               // accumulator value
   input  wire logic        reg_wr,               // register write
   input  wire logic        reg_rd,               // register read
   input  wire logic [6:0]  reg_addr,             // register address
   input  wire logic [7:0]  reg_wdata,            // write data
   input  wire logic        alu_we,               // ALU flag update
   input  wire logic [2:0]  alu_flags,            // new ALU flags
   output logic             chip_rst_q,           // core held in reset
   output logic             cold_rst_q,           // cold setup period
   output logic             sleep_q,              // core asleep
   output logic             instr_cycle_q,        // instruction cycle
   output logic             wdt_timeout_q,        // watchdog fired
   output byte_t            main_timer_count_q,   // timer value
   output byte_t            status_flags_q,       // status register
   output logic [5:0]       prescaler_control_q,  // control register
   output byte_t            reg_rdata_q           // read data
);
   localparam int HOLD_W = $clog2(RST_HOLD_CYC + 1);
   localparam int OSC_W  = $clog2(WDT_TICK_CYC + 1);

   rst_state_e        state_q;
   rst_state_e        state_d;
   logic [HOLD_W-1:0] hold_cnt_q;
   logic [OSC_W-1:0]  osc_cnt_q;
   logic [1:0]        phase_q;
   byte_t             wdt_q;
   logic              pin_s1_q;
   logic              pin_s2_q;
   logic              pin_low;
   logic              exec_ok;
   logic              exec_clrwdt;
   logic              exec_sleep;
   logic              exec_select;
   logic              tmr_wr;
   logic              st_wr;
   logic              instr_tick;
   logic              ext_edge;
   logic              src_ev;
   logic              tmr_inc;
   logic              osc_tick;
   logic              wdt_clr;
   logic              wdt_ovf;
   logic              wdt_to;
   logic              wdt_fire;
   logic              warm_go;
   logic              to_psa;

   scaler_if sif ();

   assign to_psa      = prescaler_control_q[`SEL_ASSIGN_BIT];
   assign pin_low     = !pin_s2_q;
   assign exec_ok     = instr_exec && !chip_rst_q;
   assign exec_clrwdt = exec_ok && (instr_word == `OP_CLRWDT);
   assign exec_sleep  = exec_ok && (instr_word == `OP_SLEEP);
   assign exec_select = exec_ok && (instr_word == `OP_SELECT);
   assign tmr_wr      = reg_wr && !chip_rst_q
                        && (reg_addr == `ADDR_MAIN_TIMER);
   assign st_wr       = reg_wr && !chip_rst_q && (reg_addr == `ADDR_STATUS);
   assign instr_tick  = (phase_q == `PHASE_T4) && !chip_rst_q && !sleep_q;

   // reset pin crosses in through two flops
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
      end
      else
      begin
         pin_s1_q <= reset_pin_n;
         pin_s2_q <= pin_s1_q;
      end
   end

   // four clocks per instruction cycle, T1..T4
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         phase_q       <= 2'h0;
         instr_cycle_q <= 1'b0;
      end
      else
      begin
         phase_q       <= phase_q + 2'h1;
         instr_cycle_q <= instr_tick;
      end
   end

   count_edge_sync u_edge
   (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .pin         (timer_count_pin),
      .sample_en   ((phase_q == `PHASE_T2) || (phase_q == `PHASE_T4)),
      .falling_sel (prescaler_control_q[`SEL_EDGE_BIT]),
      .edge_pulse  (ext_edge)
   );

   assign src_ev = prescaler_control_q[`SEL_SOURCE_BIT] ? ext_edge
                                                        : instr_tick;

   // one prescaler, steered by the assignment bit alone
   assign sif.ev    = to_psa ? wdt_ovf : src_ev;
   assign sif.clr   = chip_rst_q || (to_psa ? (exec_clrwdt || exec_sleep)
                                            : tmr_wr);
   assign sif.ratio = prescaler_control_q[`SEL_RATIO_MSB:0];
   assign sif.shift = !to_psa;
   assign tmr_inc   = to_psa ? src_ev : sif.tick;
   assign wdt_to    = to_psa ? sif.tick : wdt_ovf;

   ratio_scaler u_scaler
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .sif     (sif)
   );

   // software write wins over a coincident count
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         main_timer_count_q <= 8'h00;
      else if (tmr_wr)
         main_timer_count_q <= reg_wdata;
      else if (tmr_inc && !chip_rst_q)
         main_timer_count_q <= main_timer_count_q + 8'h01;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || chip_rst_q)
         prescaler_control_q <= `SEL_RESET;
      else if (exec_select)
         prescaler_control_q <= acc_in[5:0];
   end

   // stands in for the on-chip RC oscillator, which keeps running
   always_ff @(posedge clk)
   begin
      if (sys_rst || osc_tick)
         osc_cnt_q <= '0;
      else
         osc_cnt_q <= osc_cnt_q + OSC_W'(1);
   end

   assign osc_tick = (osc_cnt_q == OSC_W'(WDT_TICK_CYC - 1));
   assign wdt_clr  = exec_clrwdt || exec_sleep || chip_rst_q;
   assign wdt_ovf  = osc_tick && (wdt_q == 8'hff) && !wdt_clr;
   assign wdt_fire = wdt_to && watchdog_enable_fuse;

   always_ff @(posedge clk)
   begin
      if (sys_rst || wdt_clr)
         wdt_q <= 8'h00;
      else if (osc_tick)
         wdt_q <= wdt_q + 8'h01;
   end

   // pin reset takes priority when both causes coincide
   assign warm_go = (state_q == RUN) && (pin_low || wdt_fire);

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         COLD_HOLD:
            if (hold_cnt_q == HOLD_W'(RST_HOLD_CYC - 1))
               state_d = RUN;
         WARM_HOLD:
            if (!pin_low)
               state_d = RUN;
         RUN:
            if (warm_go)
               state_d = WARM_HOLD;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q    <= COLD_HOLD;
         hold_cnt_q <= '0;
         chip_rst_q <= 1'b1;
         cold_rst_q <= 1'b1;
      end
      else
      begin
         state_q    <= state_d;
         hold_cnt_q <= (state_q == COLD_HOLD) ? hold_cnt_q + HOLD_W'(1)
                                              : '0;
         chip_rst_q <= (state_d != RUN);
         cold_rst_q <= (state_d == COLD_HOLD);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         sleep_q <= 1'b0;
      else if (warm_go)
         sleep_q <= 1'b0;
      else if (exec_sleep)
         sleep_q <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wdt_timeout_q <= 1'b0;
      else
         wdt_timeout_q <= wdt_fire && (state_q == RUN);
   end

   // flags are hardware owned; software reaches page and ALU bits only
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         status_flags_q <= `ST_COLD_RESET;
      else if (warm_go)
      begin
         status_flags_q[`ST_PAGE_BIT] <= 1'b0;
         if (pin_low)
         begin
            if (sleep_q)
            begin
               status_flags_q[`ST_TIMEOUT_BIT] <= 1'b1;
               status_flags_q[`ST_PWRDN_BIT]   <= 1'b0;
            end
         end
         else
         begin
            status_flags_q[`ST_TIMEOUT_BIT] <= 1'b0;
            status_flags_q[`ST_PWRDN_BIT]   <= !sleep_q;
         end
      end
      else if (exec_clrwdt)
      begin
         status_flags_q[`ST_TIMEOUT_BIT] <= 1'b1;
         status_flags_q[`ST_PWRDN_BIT]   <= 1'b1;
      end
      else if (exec_sleep)
      begin
         status_flags_q[`ST_TIMEOUT_BIT] <= 1'b1;
         status_flags_q[`ST_PWRDN_BIT]   <= 1'b0;
      end
      else if (st_wr)
      begin
         status_flags_q[`ST_PAGE_BIT]      <= reg_wdata[`ST_PAGE_BIT];
         status_flags_q[`ST_ALU_MSB:0] <= reg_wdata[`ST_ALU_MSB:0];
      end
      else if (alu_we)
         status_flags_q[`ST_ALU_MSB:0] <= alu_flags;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         if (reg_addr == `ADDR_MAIN_TIMER)
            reg_rdata_q <= main_timer_count_q;
         else if (reg_addr == `ADDR_STATUS)
            reg_rdata_q <= status_flags_q;
         else
            reg_rdata_q <= 8'h00;
      end
   end

   sequence s_cold_release;
      $fell(sys_rst);
   endsequence

   sequence s_wdt_restart;
      wdt_fire && (state_q == RUN) && !pin_low;
   endsequence

   a_cold_status: assert property (@(posedge clk) disable iff (sys_rst)
      s_cold_release |-> status_flags_q[7:3] == 5'h03)
      else $error("cold status value wrong");

   a_cold_hold: assert property (@(posedge clk) disable iff (sys_rst)
      s_cold_release |-> chip_rst_q [*8])
      else $error("chip left reset too early");

   a_wdt_restart: assert property (@(posedge clk) disable iff (sys_rst)
      s_wdt_restart |=> chip_rst_q && !status_flags_q[`ST_TIMEOUT_BIT]
                        && wdt_timeout_q)
      else $error("watchdog time-out did not restart");

   a_wdt_sleep_flags: assert property (@(posedge clk) disable iff (sys_rst)
      s_wdt_restart and sleep_q |=> status_flags_q[4:3] == 2'h0)
      else $error("sleep time-out flags wrong");

   a_timer_step: assert property (@(posedge clk) disable iff (sys_rst)
      instr_tick && to_psa && !prescaler_control_q[`SEL_SOURCE_BIT]
      && !tmr_wr |=> main_timer_count_q == $past(main_timer_count_q)
                     + 8'h01)
      else $error("timer missed an instruction cycle");

   a_select_load: assert property (@(posedge clk) disable iff (sys_rst)
      exec_select && state_d == RUN
      |=> prescaler_control_q == $past(acc_in[5:0]))
      else $error("control register not loaded");

   a_sleep_flags: assert property (@(posedge clk) disable iff (sys_rst)
      exec_sleep && !warm_go |=> sleep_q
                                 && status_flags_q[4:3] == 2'h2)
      else $error("sleep flags wrong");

   a_wdt_in_sleep: assert property (@(posedge clk) disable iff (sys_rst)
      osc_tick && sleep_q && !wdt_clr
      |=> wdt_q == $past(wdt_q) + 8'h01)
      else $error("watchdog stalled while asleep");

   a_fuse_gate: assert property (@(posedge clk) disable iff (sys_rst)
      !watchdog_enable_fuse && !pin_low && state_q == RUN
      |=> state_q == RUN)
      else $error("reset without cause");
endmodule

// ### tb/count_src_model.sv
/*
   Model of the far side: external count source and reset pin driver.
   Assumes the bench calls its tasks and clk is the 40 MHz core clock.
*/
module count_src_model
(
   input  wire logic clk,   // core clock
   output logic      pin,   // count pin level
   output logic      rst_n  // reset pin, low resets
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      pin = 1'b0;
      rst_n = 1'b1;
   end

   // each level held 8..15 clocks so the phase sampler sees it at least four times
   task automatic toggles(input int n);
      repeat (n)
      begin
         repeat (8 + $urandom % 8) @(negedge clk);
         pin = ~pin;
      end
      repeat (10) @(negedge clk);
   endtask

   task automatic reset_pulse(input int len);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (len) @(negedge clk);
      rst_n = 1'b1;
   endtask
endmodule

// ### tb/tb_timer_watchdog_prescaler_reset.sv
/*
   Self-checking bench for the timer, watchdog, prescaler and reset block.
   Assumes the count source model drives the count and reset pins.
*/
`include "tmr_defs.svh"
module tb_timer_watchdog_prescaler_reset
   import tmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD_CYC = 64;
   localparam int TICK_CYC = 4;

   logic        clk, sys_rst, reset_pin_n, timer_count_pin, rd_taken;
   logic        watchdog_enable_fuse, instr_exec, reg_wr, reg_rd, alu_we;
   logic [13:0] instr_word;
   logic [7:0]  acc_in, reg_wdata;
   logic [6:0]  reg_addr;
   logic [2:0]  alu_flags, alu;
   logic        chip_rst_q, cold_rst_q, sleep_q, instr_cycle_q, wdt_timeout_q;
   byte_t       main_timer_count_q, status_flags_q, reg_rdata_q, t0, d;
   logic [5:0]  prescaler_control_q;
   byte_t       exp_q[$];
   int          err_count, checks, n_cyc;

   timer_watchdog_prescaler_reset #(
      .RST_HOLD_CYC(HOLD_CYC),
      .WDT_TICK_CYC(TICK_CYC)
   ) u_timer_watchdog_prescaler_reset (
      .clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
      .timer_count_pin(timer_count_pin),
      .watchdog_enable_fuse(watchdog_enable_fuse),
      .instr_exec(instr_exec), .instr_word(instr_word), .acc_in(acc_in),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .alu_we(alu_we), .alu_flags(alu_flags),
      .chip_rst_q(chip_rst_q), .cold_rst_q(cold_rst_q), .sleep_q(sleep_q),
      .instr_cycle_q(instr_cycle_q), .wdt_timeout_q(wdt_timeout_q),
      .main_timer_count_q(main_timer_count_q),
      .status_flags_q(status_flags_q),
      .prescaler_control_q(prescaler_control_q), .reg_rdata_q(reg_rdata_q)
   );

   count_src_model u_count_src_model (
      .clk(clk), .pin(timer_count_pin), .rst_n(reset_pin_n)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic conclude();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what,
                  got, exp);
      end
   endtask

   task automatic rng(input int got, input int lo, input int hi,
                      input string what);
      checks++;
      if (got < lo || got > hi)
      begin
         err_count++;
         $display("Error at %0t: %s took %0d cycles", $time, what, got);
      end
   endtask

   task automatic exec(input logic [13:0] w, input logic [7:0] a);
      @(negedge clk);
      instr_exec = 1'b1;
      instr_word = w;
      acc_in = a;
      @(negedge clk);
      instr_exec = 1'b0;
   endtask

   task automatic wr(input logic [6:0] a, input byte_t v);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   // the expected byte waits in the queue until the monitor sees the read
   task automatic rd(input logic [6:0] a, input byte_t v);
      exp_q.push_back(v);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
   endtask

   task automatic cycles(input int n);
      repeat (n)
      begin
         @(negedge clk);
         for (int i = 0; i < 8 && instr_cycle_q !== 1'b1; i++)
            @(negedge clk);
      end
   endtask

   // sampled at the same instruction phase so prescaler phase cancels
   task automatic tdelta(input int n, input int e);
      cycles(1);
      t0 = main_timer_count_q;
      cycles(n);
      cmp(8'(main_timer_count_q - t0), e, "timer step");
   endtask

   task automatic settle();
      repeat (3) @(negedge clk);
      n_cyc = 0;
      while (chip_rst_q !== 1'b0 && n_cyc < 200)
      begin
         @(negedge clk);
         n_cyc++;
      end
      cmp(chip_rst_q, 1'b0, "reset release");
   endtask

   task automatic wdt_wait(input int lim);
      n_cyc = 0;
      while (wdt_timeout_q !== 1'b1 && n_cyc < lim)
      begin
         @(negedge clk);
         n_cyc++;
      end
   endtask

   always @(posedge clk) rd_taken <= reg_rd;

   always @(negedge clk)
      if (rd_taken === 1'b1 && exp_q.size() > 0)
         cmp(reg_rdata_q, exp_q.pop_front(), "read data");

   initial
   begin
      #1_000_000;
      err_count++;
      conclude();
   end

   initial
   begin
      sys_rst = 1'b1;
      watchdog_enable_fuse = 1'b0;
      instr_exec = 1'b0;
      instr_word = 14'h0000;
      acc_in = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      alu_we = 1'b0;
      alu_flags = 3'h0;
      void'($urandom(32'h0000_a8b9));
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      cmp(cold_rst_q, 1'b1, "cold flag");
      cmp(prescaler_control_q, 6'h3f, "control");
      rd(`ADDR_STATUS, `ST_COLD_RESET);
      n_cyc = 0;
      while (chip_rst_q !== 1'b0 && n_cyc < 200)
      begin
         @(negedge clk);
         n_cyc++;
      end
      rng(n_cyc, HOLD_CYC - 6, HOLD_CYC + 4, "cold hold");
      cmp(cold_rst_q, 1'b0, "cold flag");
      rd(7'h05, 8'h00);
      alu = 3'($urandom);
      wr(`ADDR_STATUS, 8'hff);
      rd(`ADDR_STATUS, 8'h3f);
      @(negedge clk);
      alu_we = 1'b1;
      alu_flags = alu;
      @(negedge clk);
      alu_we = 1'b0;
      rd(`ADDR_STATUS, {3'b001, 2'b11, alu});
      // control is 3f here: pin source with a still pin, so no counting
      d = 8'($urandom);
      wr(`ADDR_MAIN_TIMER, d);
      rd(`ADDR_MAIN_TIMER, d);
      u_count_src_model.reset_pulse(6);
      settle();
      cmp(cold_rst_q, 1'b0, "warm is not cold");
      rd(`ADDR_MAIN_TIMER, d);
      rd(`ADDR_STATUS, {3'b000, 2'b11, alu});
      cmp(prescaler_control_q, 6'h3f, "control");
      exec(`OP_SELECT, 8'h08);
      cmp(prescaler_control_q, 6'h08, "control");
      tdelta(6, 6);
      for (int n = 0; n < 4; n++)
      begin
         exec(`OP_SELECT, 8'(n));
         tdelta(4 << (n + 1), 4);
      end
      exec(`OP_CLRWDT, 8'h00);
      exec(`OP_SELECT, 8'h28);
      t0 = main_timer_count_q;
      u_count_src_model.toggles(5);
      cmp(8'(main_timer_count_q - t0), 3, "rising");
      exec(`OP_SELECT, 8'h38);
      repeat (4) @(negedge clk);
      t0 = main_timer_count_q;
      u_count_src_model.toggles(3);
      cmp(8'(main_timer_count_q - t0), 2, "falling");
      exec(`OP_SELECT, 8'h08);
      exec(`OP_CLRWDT, 8'h00);
      wdt_wait(1500);
      cmp(n_cyc, 1500, "unfused");
      watchdog_enable_fuse = 1'b1;
      repeat (3)
      begin
         exec(`OP_CLRWDT, 8'h00);
         wdt_wait(700);
         cmp(n_cyc, 700, "cleared");
      end
      for (int n = 0; n < 3; n++)
      begin
         exec(`OP_SELECT, 8'h08 | 8'(n));
         exec(`OP_CLRWDT, 8'h00);
         wdt_wait(10000);
         rng(n_cyc, ((256 - 1) << n) * TICK_CYC - 8,
             (256 << n) * TICK_CYC + TICK_CYC + 8, "period");
         settle();
         rd(`ADDR_STATUS, {3'b000, 2'b01, alu});
         cmp(prescaler_control_q, 6'h3f, "control");
      end
      exec(`OP_SELECT, 8'h08);
      exec(`OP_SLEEP, 8'h00);
      cmp(sleep_q, 1'b1, "asleep");
      rd(`ADDR_STATUS, {3'b000, 2'b10, alu});
      wdt_wait(1200);
      rng(n_cyc, 255 * TICK_CYC - 12, 256 * TICK_CYC + 8, "sleep wdt");
      settle();
      rd(`ADDR_STATUS, {3'b000, 2'b00, alu});
      cmp(sleep_q, 1'b0, "awake");
      exec(`OP_SLEEP, 8'h00);
      u_count_src_model.reset_pulse(6);
      settle();
      rd(`ADDR_STATUS, {3'b000, 2'b10, alu});
      repeat (4) @(negedge clk);
      conclude();
   end
endmodule
